// ===== logic/hws_regs.svh
/*
 halt/wakeup sequencer constants: preset values, divider and delay counts.
 assumes a 50 MHz system clock standing in for the oscillator clock.
*/
`ifndef HWS_REGS_SVH
`define HWS_REGS_SVH
`define HWS_WD_PRESET 8'hFF
`define HWS_TC_DIV 10
`define HWS_START_DELAY_TC 256
`define HWS_RESUME_NEXT 1'b0
`define HWS_RESUME_ZERO 1'b1
`define HWS_RESET_VECTOR 16'h0000
`endif

// ===== logic/hws_pkg.sv
/*
 halt/wakeup sequencer types.
 assumes the constants header holds all numeric values.
*/
package hws_pkg;
    typedef enum logic [3:0] {
        HWS_RUN = 4'h1,
        HWS_HALT = 4'h2,
        HWS_START = 4'h4,
        HWS_RESYNC = 4'h8
    } hws_state_t;
    typedef enum logic [1:0] {
        HWS_WK_NONE = 2'h0,
        HWS_WK_PIN = 2'h1,
        HWS_WK_PORT = 2'h2,
        HWS_WK_BROWN = 2'h3
    } hws_wake_t;
endpackage : hws_pkg

// ===== logic/hws_sync.sv
/*
 two-flop synchroniser for one level from outside the clock domain.
 assumes reset value zero is safe for the level.
*/
`timescale 1ns/1ns
module hws_sync (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta_q;
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= 1'b0;
            q_o <= 1'b0;
        end
        else
        begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule : hws_sync

// ===== logic/hws_wdog_timer.sv
/*
 start-up timer: 8-bit prescaler feeding 8-bit counter, both preset to FF.
 assumes tick_i is a one-cycle instruction-cycle tick.
*/
`timescale 1ns/1ns
`include "hws_regs.svh"
module hws_wdog_timer #(
    parameter int WIDTH = 8
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic load_i,
    input wire logic run_i,
    input wire logic tick_i,
    output logic [WIDTH-1:0] prescale_o,
    output logic [WIDTH-1:0] count_o,
    output logic expire_o
);
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            prescale_o <= `HWS_WD_PRESET;
            count_o <= `HWS_WD_PRESET;
        end
        else if (ce_i)
        begin
            if (load_i)
            begin
                prescale_o <= `HWS_WD_PRESET;
                count_o <= `HWS_WD_PRESET;
            end
            else if (run_i && tick_i)
            begin
                prescale_o <= prescale_o - 1'b1;
                if (prescale_o == '0)
                    count_o <= count_o - 1'b1;
            end
        end
    end
    // timeout when the first counter step after load happens
    assign expire_o = run_i && tick_i && (prescale_o == '0);
endmodule : hws_wdog_timer

// ===== logic/hws_halt_seq.sv
/*
 halt/wakeup sequencer: halt entry, clock gating, wake detection,
 crystal start-up delay, resume address choice and retention flags.
 assumes cpu logic obeys clk_run_o and the restart/reset outputs.
*/
`timescale 1ns/1ns
`include "hws_regs.svh"
module hws_halt_seq #(
    parameter int DIV = `HWS_TC_DIV
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic crystal_opt_i,
    input wire logic brown_opt_i,
    input wire logic halt_write_i,
    input wire logic halt_restart_pin_i,
    input wire logic port_wake_i,
    input wire logic ext_reset_n_i,
    input wire logic brown_low_i,
    output logic halted_o,
    output logic osc_en_o,
    output logic clk_run_o,
    output logic dev_reset_o,
    output logic resume_zero_o,
    output logic restart_pin_data_o,
    output logic acc_timer_lost_o,
    output logic data_lost_o,
    output logic wd_altered_o,
    output logic [7:0] wd_prescale_o,
    output logic [7:0] wd_count_o
);
    hws_pkg::hws_state_t state_q;
    hws_pkg::hws_state_t state_d;
    logic pin_s;
    logic port_s;
    logic rst_n_s;
    logic brown_s;
    logic pin_prev_q;
    logic [3:0] div_q;
    logic tick;
    logic wd_load;
    logic wd_run;
    logic wd_expire;
    logic brown_act;
    logic ext_act;
    logic pin_rise;
    logic [7:0] pre_w;
    logic [7:0] cnt_w;
    logic [8:0] start_ticks_q;

    // each wake source is resynchronised on the free-running oscillator
    hws_sync u_pin (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .d_i(halt_restart_pin_i), .q_o(pin_s));
    hws_sync u_port (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .d_i(port_wake_i), .q_o(port_s));
    hws_sync u_rst (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .d_i(ext_reset_n_i), .q_o(rst_n_s));
    hws_sync u_brn (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .d_i(brown_low_i), .q_o(brown_s));

    assign ext_act = !rst_n_s;
    // monitor never gated by halt state; masked by option and by reset pin
    assign brown_act = brown_opt_i && brown_s && !ext_act;
    assign pin_rise = pin_s && !pin_prev_q && !crystal_opt_i;
    assign tick = (div_q == 4'(DIV - 1));
    // preset only on a write that really enters halt
    assign wd_load = (state_q == hws_pkg::HWS_RUN) && halt_write_i
        && !ext_act && !brown_act;
    assign wd_run = (state_q == hws_pkg::HWS_START);

    hws_wdog_timer #(.WIDTH(8)) u_wd (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .load_i(wd_load),
        .run_i(wd_run),
        .tick_i(tick),
        .prescale_o(pre_w),
        .count_o(cnt_w),
        .expire_o(wd_expire)
    );

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            div_q <= 4'h0;
        else if (ce_i)
            div_q <= tick ? 4'h0 : div_q + 4'h1;
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pin_prev_q <= 1'b0;
        else if (ce_i)
            pin_prev_q <= pin_s;
    end

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            hws_pkg::HWS_RUN:
                if (halt_write_i && !ext_act && !brown_act)
                    state_d = hws_pkg::HWS_HALT;
            hws_pkg::HWS_HALT:
                if (ext_act)
                    state_d = hws_pkg::HWS_RESYNC;
                else if (brown_act || port_s)
                    state_d = crystal_opt_i ? hws_pkg::HWS_START
                        : hws_pkg::HWS_RESYNC;
                else if (pin_rise)
                    state_d = hws_pkg::HWS_RESYNC;
            hws_pkg::HWS_START:
                if (ext_act)
                    state_d = hws_pkg::HWS_RESYNC;
                else if (wd_expire)
                    state_d = hws_pkg::HWS_RESYNC;
            hws_pkg::HWS_RESYNC:
                state_d = hws_pkg::HWS_RUN;
            default:
                state_d = hws_pkg::HWS_RUN;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            state_q <= hws_pkg::HWS_RUN;
        else if (ce_i)
            state_q <= state_d;
    end

    // cause bookkeeping captured at the moment of wake
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            resume_zero_o <= `HWS_RESUME_ZERO;
            acc_timer_lost_o <= 1'b0;
            data_lost_o <= 1'b0;
            wd_altered_o <= 1'b0;
        end
        else if (ce_i && state_q == hws_pkg::HWS_HALT
            && state_d != hws_pkg::HWS_HALT)
        begin
            resume_zero_o <= (ext_act || brown_act) ? `HWS_RESUME_ZERO
                : `HWS_RESUME_NEXT;
            acc_timer_lost_o <= (ext_act && crystal_opt_i)
                || brown_act;
            data_lost_o <= !ext_act && brown_act;
            wd_altered_o <= 1'b1;
        end
        else if (ce_i && state_q == hws_pkg::HWS_START && ext_act)
        begin
            // reset pin during start-up still restarts from zero
            resume_zero_o <= `HWS_RESUME_ZERO;
            acc_timer_lost_o <= 1'b1;
        end
        else if (ce_i && wd_load)
        begin
            acc_timer_lost_o <= 1'b0;
            data_lost_o <= 1'b0;
            wd_altered_o <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            halted_o <= 1'b0;
            osc_en_o <= 1'b1;
            clk_run_o <= 1'b1;
            dev_reset_o <= 1'b1;
            restart_pin_data_o <= 1'b0;
            wd_prescale_o <= `HWS_WD_PRESET;
            wd_count_o <= `HWS_WD_PRESET;
        end
        else if (ce_i)
        begin
            halted_o <= state_d != hws_pkg::HWS_RUN;
            // oscillator alone runs during start-up
            osc_en_o <= state_d != hws_pkg::HWS_HALT;
            clk_run_o <= state_d == hws_pkg::HWS_RUN;
            // reset held while pin low or, with the brown-out option on, supply low
            dev_reset_o <= ext_act || brown_act;
            if (state_q == hws_pkg::HWS_RUN)
                restart_pin_data_o <= pin_s;
            wd_prescale_o <= pre_w;
            wd_count_o <= cnt_w;
        end
    end

    // software contract: two no-ops after halt cover the resync state

    // ticks seen during start-up, counted apart from the timer itself
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            start_ticks_q <= 9'h000;
        else if (ce_i)
        begin
            if (state_q != hws_pkg::HWS_START)
                start_ticks_q <= 9'h000;
            else if (tick)
                start_ticks_q <= start_ticks_q + 9'h001;
        end
    end

    chk_halt_entry: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        ce_i && state_q == hws_pkg::HWS_RUN && halt_write_i && !ext_act
        && !brown_act |=> !clk_run_o)
        else $error("halt write did not stop clocks");
    chk_clock_gated: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        state_q == hws_pkg::HWS_HALT |-> !clk_run_o)
        else $error("clock running in halt");
    chk_pin_crystal: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        ce_i && state_q == hws_pkg::HWS_HALT && crystal_opt_i && pin_s
        && !port_s && !ext_act && !brown_act
        |=> state_q == hws_pkg::HWS_HALT)
        else $error("pin edge woke crystal part");
    chk_ext_exit: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        ce_i && state_q == hws_pkg::HWS_HALT && ext_act
        |=> state_q == hws_pkg::HWS_RESYNC)
        else $error("reset pin did not end halt");
    chk_reset_no_delay: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        ce_i && state_q == hws_pkg::HWS_HALT && ext_act
        |=> state_q != hws_pkg::HWS_START)
        else $error("delay started on reset exit");
    chk_rc_no_delay: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        !crystal_opt_i |-> state_q != hws_pkg::HWS_START)
        else $error("delay used without crystal");
    chk_zero_vector: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        ce_i && state_q == hws_pkg::HWS_HALT && ext_act
        |=> resume_zero_o)
        else $error("reset exit not to zero");
    chk_port_resume: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        ce_i && state_q == hws_pkg::HWS_HALT && port_s && !ext_act
        && !brown_act |=> !resume_zero_o)
        else $error("port wake not resuming next");
    chk_acc_lost: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        ce_i && state_q == hws_pkg::HWS_HALT && ext_act && crystal_opt_i
        |=> acc_timer_lost_o)
        else $error("crystal reset exit kept accumulator");
    chk_data_lost: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        ce_i && state_q == hws_pkg::HWS_HALT && brown_act
        |=> data_lost_o)
        else $error("brown-out exit kept data");
    chk_pin_read: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        ce_i && state_q == hws_pkg::HWS_RUN
        |=> restart_pin_data_o == $past(pin_s))
        else $error("restart pin not readable while running");
    chk_brown_reset: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        ce_i && brown_act |=> dev_reset_o)
        else $error("brown-out reset missing");
    chk_halt_preset: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        ce_i && wd_load |=> pre_w == 8'hFF && cnt_w == 8'hFF)
        else $error("timer not preset on halt");
    chk_delay_cancel: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        ce_i && state_q == hws_pkg::HWS_START && ext_act
        |=> state_q == hws_pkg::HWS_RESYNC && resume_zero_o)
        else $error("reset did not cancel delay");
    chk_osc_start: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        state_q == hws_pkg::HWS_START |-> !clk_run_o)
        else $error("clocks before start-up timeout");
    chk_delay_length: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        ce_i && state_q == hws_pkg::HWS_START
        && state_d == hws_pkg::HWS_RESYNC && !ext_act
        |-> start_ticks_q == 9'(`HWS_START_DELAY_TC - 1))
        else $error("start-up delay length wrong");
    chk_start_expire: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        ce_i && state_q == hws_pkg::HWS_START && wd_expire && !ext_act
        |=> state_q == hws_pkg::HWS_RESYNC)
        else $error("timeout did not release clocks");
    chk_resync_run: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        ce_i && state_q == hws_pkg::HWS_RESYNC
        |=> clk_run_o && state_q == hws_pkg::HWS_RUN)
        else $error("clocks not back after resync");

    cov_port_crystal: cover property (@(posedge clock_i)
        state_q == hws_pkg::HWS_START ##1 state_q == hws_pkg::HWS_RESYNC);
    cov_pin_wake: cover property (@(posedge clock_i)
        state_q == hws_pkg::HWS_HALT && pin_rise);
    cov_reset_exit: cover property (@(posedge clock_i)
        state_q == hws_pkg::HWS_HALT && ext_act);
    cov_brown_wake: cover property (@(posedge clock_i)
        state_q == hws_pkg::HWS_HALT && brown_act);
    cov_delay_cancel: cover property (@(posedge clock_i)
        state_q == hws_pkg::HWS_START && ext_act);
endmodule : hws_halt_seq

// ===== tb/halt_wakeup_sequencer_tb_top.sv
/*
 self-checking bench for the halt/wakeup sequencer: halt entry, each wake
 source, crystal start-up delay, resume address and retention flags.
 assumes the sequencer's own assertions run alongside; DIV shortened to 2.
*/
`timescale 1ns/1ns
module halt_wakeup_sequencer_tb_top;
    localparam int DIV = 2;
    localparam int DELAY = 256 * DIV;
    logic clock_i, rst_n_i, ce_i, crystal_opt_i, brown_opt_i, halt_write_i;
    logic halt_restart_pin_i, port_wake_i, ext_reset_n_i, brown_low_i;
    logic halted_o, osc_en_o, clk_run_o, dev_reset_o, resume_zero_o;
    logic restart_pin_data_o, acc_timer_lost_o, data_lost_o, wd_altered_o;
    logic [7:0] wd_prescale_o;
    logic [7:0] wd_count_o;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    int n;
    int i;

    hws_halt_seq #(.DIV(DIV)) i_hws_halt_seq (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .crystal_opt_i(crystal_opt_i), .brown_opt_i(brown_opt_i),
        .halt_write_i(halt_write_i), .halt_restart_pin_i(halt_restart_pin_i),
        .port_wake_i(port_wake_i), .ext_reset_n_i(ext_reset_n_i),
        .brown_low_i(brown_low_i), .halted_o(halted_o), .osc_en_o(osc_en_o),
        .clk_run_o(clk_run_o), .dev_reset_o(dev_reset_o),
        .resume_zero_o(resume_zero_o),
        .restart_pin_data_o(restart_pin_data_o),
        .acc_timer_lost_o(acc_timer_lost_o), .data_lost_o(data_lost_o),
        .wd_altered_o(wd_altered_o), .wd_prescale_o(wd_prescale_o),
        .wd_count_o(wd_count_o));

    initial
    begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    task conclude;
        $display("errors=%0d compares=%0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude

    // ceiling well above the longest sequence (a few crystal delays)
    always @(posedge clock_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            err_count++;
            $display("MISMATCH t=%0t run did not finish", $time);
            conclude();
        end
    end

    task check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1)
        begin
            err_count++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask : check

    task halt_now;
        @(negedge clock_i) halt_write_i = 1'b1;
        @(negedge clock_i) halt_write_i = 1'b0;
        @(negedge clock_i);
    endtask : halt_now

    // bounded wait for the cpu clock gate to reopen
    task wait_run(output int c);
        c = 0;
        while (clk_run_o !== 1'b1 && c < 3000)
        begin
            @(negedge clock_i);
            c++;
        end
    endtask : wait_run

    initial
    begin
        n = $urandom(76);
        {ce_i, brown_opt_i, ext_reset_n_i} = 3'h7;
        {rst_n_i, crystal_opt_i, halt_write_i} = 3'h0;
        {halt_restart_pin_i, port_wake_i, brown_low_i} = 3'h0;
        // one rising edge under reset before the first look
        @(posedge clock_i);
        @(negedge clock_i);
        check(wd_prescale_o === 8'hFF && wd_count_o === 8'hFF, "wdr");
        check(resume_zero_o === 1'b1 && dev_reset_o === 1'b1, "reset out");
        repeat (3) @(negedge clock_i);
        rst_n_i = 1'b1;
        repeat (5) @(negedge clock_i);
        check(dev_reset_o === 1'b0 && clk_run_o === 1'b1, "after reset");
        halt_restart_pin_i = 1'b1;
        repeat (4) @(negedge clock_i);
        check(restart_pin_data_o === 1'b1, "pin read high");
        halt_restart_pin_i = 1'b0;
        repeat (4) @(negedge clock_i);
        check(restart_pin_data_o === 1'b0, "pin read low");
        // enable low: a halt write must not be taken
        ce_i = 1'b0;
        halt_write_i = 1'b1;
        repeat (3) @(negedge clock_i);
        check(clk_run_o === 1'b1 && halted_o === 1'b0, "ce freeze");
        {ce_i, halt_write_i} = 2'h2;
        halt_now();
        check(halted_o === 1'b1 && clk_run_o === 1'b0, "halt entry");
        check(wd_prescale_o === 8'hFF && wd_count_o === 8'hFF, "wdl");
        repeat (20) @(negedge clock_i);
        check(clk_run_o === 1'b0 && restart_pin_data_o === 1'b0, "held");
        halt_restart_pin_i = 1'b1;
        wait_run(n);
        check(n < 10 && resume_zero_o === 1'b0, "pin wake");
        check(acc_timer_lost_o === 1'b0 && data_lost_o === 1'b0, "kept");
        check(wd_altered_o === 1'b1, "rc wd altered");
        halt_restart_pin_i = 1'b0;
        crystal_opt_i = 1'b1;
        halt_now();
        halt_restart_pin_i = 1'b1;
        repeat (20) @(negedge clock_i);
        check(halted_o === 1'b1 && clk_run_o === 1'b0, "crystal pin");
        halt_restart_pin_i = 1'b0;
        port_wake_i = 1'b1;
        repeat (6) @(negedge clock_i);
        check(osc_en_o === 1'b1 && clk_run_o === 1'b0, "osc only");
        port_wake_i = 1'b0;
        wait_run(n);
        check(n + 6 >= DELAY && n + 6 <= DELAY + 20, "start delay");
        check(resume_zero_o === 1'b0, "port resume next");
        crystal_opt_i = 1'b0;
        halt_now();
        port_wake_i = 1'b1;
        wait_run(n);
        check(n < 10 && wd_altered_o === 1'b1, "rc port no delay");
        port_wake_i = 1'b0;
        crystal_opt_i = 1'b1;
        halt_now();
        ext_reset_n_i = 1'b0;
        repeat (5) @(negedge clock_i);
        check(dev_reset_o === 1'b1 && halted_o === 1'b0, "ext exit");
        ext_reset_n_i = 1'b1;
        wait_run(n);
        check(n < 10 && resume_zero_o === 1'b1, "ext no delay");
        check(acc_timer_lost_o === 1'b1, "acc lost");
        // synced reset pin must settle, else the halt write is refused
        repeat (4) @(negedge clock_i);
        halt_now();
        brown_low_i = 1'b1;
        repeat (5) @(negedge clock_i);
        check(dev_reset_o === 1'b1, "brown reset");
        brown_low_i = 1'b0;
        wait_run(n);
        check(n <= DELAY + 20 && resume_zero_o === 1'b1, "brown exit");
        check(data_lost_o === 1'b1, "data lost");
        // brown-out masked off: the supply dip must not wake or reset
        brown_opt_i = 1'b0;
        halt_now();
        brown_low_i = 1'b1;
        repeat (10) @(negedge clock_i);
        check(halted_o === 1'b1 && dev_reset_o === 1'b0, "brown off");
        brown_low_i = 1'b0;
        repeat (4) @(negedge clock_i);
        brown_opt_i = 1'b1;
        port_wake_i = 1'b1;
        repeat (20) @(negedge clock_i);
        port_wake_i = 1'b0;
        ext_reset_n_i = 1'b0;
        repeat (5) @(negedge clock_i);
        ext_reset_n_i = 1'b1;
        wait_run(n);
        check(n < 20 && resume_zero_o === 1'b1, "ext cancel");
        crystal_opt_i = 1'b0;
        repeat (4) @(negedge clock_i);
        for (i = 0; i < 8; i++)
        begin
            halt_now();
            repeat ($urandom_range(1, 30)) @(negedge clock_i);
            if ($urandom_range(0, 1) == 1)
                halt_restart_pin_i = 1'b1;
            else
                port_wake_i = 1'b1;
            wait_run(n);
            check(n < 10 && resume_zero_o === 1'b0, "random wake");
            {halt_restart_pin_i, port_wake_i} = 2'h0;
            // idle cycles after wake stand in for the two no-ops
            repeat (4) @(negedge clock_i);
        end
        conclude();
    end
endmodule : halt_wakeup_sequencer_tb_top
